/* File: include/rtctb_pkg.sv */
package rtctb_pkg;
  localparam int unsigned PCLK_HZ    = 200_000_000;
  localparam int unsigned XTAL_HZ    = 32_768;
  // Timing figures in their own units
  localparam int unsigned TMO_MIN_MS = 25;
  localparam int unsigned TMO_MAX_MS = 35;
  localparam int unsigned OSF_MS     = 25;
  localparam int unsigned SKEW_US    = 7_800;
  localparam int unsigned TOL_PPM    = 8_000;
  // Least times round up, longest round down
  localparam int unsigned TMO_MIN_TICKS = (TMO_MIN_MS * XTAL_HZ + 999) / 1000;
  localparam int unsigned TMO_MAX_TICKS = (TMO_MAX_MS * XTAL_HZ) / 1000;
  localparam int unsigned OSF_CYCLES    = OSF_MS * (PCLK_HZ / 1000);
  localparam int unsigned SKEW_TICKS    = (SKEW_US * XTAL_HZ) / 1_000_000;
  // Divide last: an early divide drops the fraction of the crystal rate
  localparam int unsigned TOL_TICKS     = XTAL_HZ * TOL_PPM / 1_000_000;
  // Reference divisors per select code
  localparam logic [15:0] DIV_SEL0 = 16'h0001;
  localparam logic [15:0] DIV_SEL1 = 16'h0032;
  localparam logic [15:0] DIV_SEL2 = 16'h003C;
  localparam logic [15:0] DIV_SEL3 = 16'h8000;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TIME   = 8'h08;
  localparam logic [7:0] OFF_DATE   = 8'h0C;
  localparam logic [7:0] OFF_ALM1   = 8'h10;
  localparam logic [7:0] OFF_ALM2   = 8'h14;
  // Control fields
  localparam int unsigned C_OSC_OFF = 0;
  localparam int unsigned C_EXT_EN  = 1;
  localparam int unsigned C_DIV_LO  = 2;
  localparam int unsigned C_MODE12  = 4;
  localparam int unsigned C_INTCN   = 5;
  localparam int unsigned C_A1IE    = 6;
  localparam int unsigned C_A2IE    = 7;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  // Status fields, write one to clear
  localparam int unsigned S_A1F  = 0;
  localparam int unsigned S_A2F  = 1;
  localparam int unsigned S_LOST = 2;
  localparam int unsigned S_HALT = 3;
  localparam int unsigned S_TMO  = 4;
  localparam logic [3:0]  STAT_RST = 4'h8;
  // Time and date word fields
  localparam int unsigned T_SEC = 0;
  localparam int unsigned T_MIN = 8;
  localparam int unsigned T_HR  = 16;
  localparam int unsigned T_PM  = 21;
  localparam int unsigned D_DOW = 0;
  localparam int unsigned D_DAT = 8;
  localparam int unsigned D_MON = 16;
  localparam int unsigned D_YR  = 24;
  typedef enum logic {REF_HUNT, REF_LOCK} rtctb_lock_t;
endpackage : rtctb_pkg

/* File: rtl/rtctb_cal.sv */
`timescale 1ns/1ps
module rtctb_cal
  import rtctb_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       sec_tick,
  input  wire logic       load_time,
  input  wire logic       load_date,
  input  wire logic [5:0] new_sec,
  input  wire logic [5:0] new_min,
  input  wire logic [4:0] new_hour,
  input  wire logic [2:0] new_dow,
  input  wire logic [4:0] new_date,
  input  wire logic [3:0] new_month,
  input  wire logic [6:0] new_year,
  output logic      [5:0] sec_q,
  output logic      [5:0] min_q,
  output logic      [4:0] hour_q,
  output logic      [2:0] dow_q,
  output logic      [4:0] date_q,
  output logic      [3:0] month_q,
  output logic      [6:0] year_q
);
  logic [4:0] last_day;
  logic       leap;
  logic       c_min;
  logic       c_hour;
  logic       c_day;
  logic       c_mon;
  logic       c_yr;

  // Every year 00..99 divisible by four is a leap year in 2000..2099
  assign leap     = (year_q[1:0] == 2'b00);
  assign last_day = (month_q == 4'd2) ? (leap ? 5'd29 : 5'd28) :
                    (month_q == 4'd4 || month_q == 4'd6 ||
                     month_q == 4'd9 || month_q == 4'd11) ? 5'd30 : 5'd31;
  assign c_min  = sec_tick && sec_q == 6'd59;
  assign c_hour = c_min && min_q == 6'd59;
  assign c_day  = c_hour && hour_q == 5'd23;
  assign c_mon  = c_day && date_q >= last_day;
  assign c_yr   = c_mon && month_q == 4'd12;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_q   <= '0;
      min_q   <= '0;
      hour_q  <= '0;
      dow_q   <= 3'h1;
      date_q  <= 5'h01;
      month_q <= 4'h1;
      year_q  <= '0;
    end else begin
      if (load_time) begin
        sec_q  <= new_sec;
        min_q  <= new_min;
        hour_q <= new_hour;
      end else if (sec_tick) begin
        sec_q  <= c_min ? 6'd0 : sec_q + 6'd1;
        if (c_min)  min_q  <= c_hour ? 6'd0 : min_q + 6'd1;
        if (c_hour) hour_q <= c_day ? 5'd0 : hour_q + 5'd1;
      end
      if (load_date) begin
        dow_q   <= new_dow;
        date_q  <= new_date;
        month_q <= new_month;
        year_q  <= new_year;
      end else if (c_day && !load_time) begin
        dow_q  <= (dow_q == 3'd7) ? 3'd1 : dow_q + 3'd1;
        date_q <= c_mon ? 5'd1 : date_q + 5'd1;
        if (c_mon) month_q <= c_yr ? 4'd1 : month_q + 4'd1;
        if (c_yr)  year_q  <= (year_q == 7'd99) ? 7'd0 : year_q + 7'd1;
      end
    end
  end
endmodule : rtctb_cal

/* File: rtl/rtctb_sync.sv */
`timescale 1ns/1ps
module rtctb_sync
  import rtctb_pkg::*;
#(
  parameter int unsigned W = 3
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : rtctb_sync

/* File: rtl/rtctb_top.sv */
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module rtctb_top
  import rtctb_pkg::*;
#(
  parameter int unsigned OSF_LIMIT = OSF_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        xtal_clk,
  input  wire logic        refin_or_irq_a_pin_i,
  output logic             refin_or_irq_a_pin_o,
  output logic             refin_or_irq_a_pin_oe,
  output logic             wave_or_irq_b_pin,
  input  wire logic        scl_i,
  input  wire logic        sda_drive_req,
  input  wire logic        wr_byte_pending,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             bus_reset,
  output logic             byte_discard
);
  // ==========================================================
  // Pin synchronisers and edge detection
  logic [2:0]  pins_s;
  logic        xtal_p_q;
  logic        ref_p_q;
  logic        xtal_edge;
  logic        ref_edge;
  logic        scl_s;

  rtctb_sync #(.W(3)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({scl_i, refin_or_irq_a_pin_i, xtal_clk}),
    .sync_out (pins_s)
  );

  // ==========================================================
  // Register state
  logic [7:0]  ctrl_q;
  logic [4:0]  stat_q;
  logic [16:0] alm1_q;
  logic [16:0] alm2_q;
  logic        osc_off_bit;
  logic        ext_ref_enable;
  logic [1:0]  ref_divisor_select;
  logic        mode12;

  assign osc_off_bit        = ctrl_q[C_OSC_OFF];
  assign ext_ref_enable     = ctrl_q[C_EXT_EN];
  assign ref_divisor_select = ctrl_q[C_DIV_LO +: 2];
  assign mode12             = ctrl_q[C_MODE12];
  assign scl_s              = pins_s[2];

  // A stopped oscillator gives no edges at all
  assign xtal_edge = pins_s[0] && !xtal_p_q && !osc_off_bit;
  // Pin A is only a reference input while the reference is enabled
  assign ref_edge  = pins_s[1] && !ref_p_q && ext_ref_enable;

  // ==========================================================
  // Reference divider
  logic [15:0] ref_div_q;
  logic [15:0] divisor;
  logic        ref_derived_pps;

  assign divisor = (ref_divisor_select == 2'd0) ? DIV_SEL0 :
                   (ref_divisor_select == 2'd1) ? DIV_SEL1 :
                   (ref_divisor_select == 2'd2) ? DIV_SEL2 : DIV_SEL3;
  assign ref_derived_pps = ref_edge && (ref_div_q >= divisor - 16'h0001);

  // ==========================================================
  // Crystal divider, tolerance check and lock
  logic [14:0] xdiv_q;
  logic [14:0] xdiv_d;
  logic [14:0] lock_ph_q;
  logic [14:0] skew;
  logic [14:0] skew_abs;
  logic [16:0] refper_q;
  logic        xtal_derived_pps;
  logic        in_tol;
  logic        too_long;
  logic        ref_bad;
  logic        need_adj;
  rtctb_lock_t lock_q;

  localparam logic [16:0] PER_LO  = 17'(XTAL_HZ - TOL_TICKS);
  localparam logic [16:0] PER_HI  = 17'(XTAL_HZ + TOL_TICKS);
  localparam logic [14:0] SKEW_LIM = 15'(SKEW_TICKS);

  assign xtal_derived_pps = xtal_edge && (xdiv_q == 15'h7FFF);
  // Measured in crystal ticks, so only meaningful with the oscillator running
  assign in_tol   = refper_q >= PER_LO && refper_q <= PER_HI;
  assign too_long = refper_q > PER_HI;
  assign ref_bad  = ext_ref_enable && !osc_off_bit &&
                    ((ref_derived_pps && !in_tol) || too_long);
  assign skew     = xdiv_q - lock_ph_q;
  assign skew_abs = skew[14] ? 15'(-skew) : skew;
  // Wrong-phase reference edges pull the divider only at or past the skew limit
  assign need_adj = ref_derived_pps && in_tol && lock_q == REF_LOCK &&
                    skew_abs >= SKEW_LIM;

  always_comb begin
    xdiv_d = xdiv_q;
    if (need_adj) begin
      xdiv_d = lock_ph_q;
    end else if (xtal_edge) begin
      xdiv_d = xdiv_q + 15'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_p_q  <= 1'b0;
      ref_p_q   <= 1'b0;
      ref_div_q <= '0;
      xdiv_q    <= '0;
      refper_q  <= '0;
      lock_ph_q <= '0;
      lock_q    <= REF_HUNT;
    end else begin
      xtal_p_q <= pins_s[0];
      ref_p_q  <= pins_s[1];
      xdiv_q   <= xdiv_d;
      if (!ext_ref_enable) begin
        ref_div_q <= '0;
      end else if (ref_edge) begin
        ref_div_q <= ref_derived_pps ? 16'h0000 : ref_div_q + 16'h0001;
      end
      if (ref_derived_pps) begin
        refper_q <= '0;
      end else if (xtal_edge && !too_long) begin
        refper_q <= refper_q + 17'h00001;
      end
      unique case (lock_q)
        REF_HUNT: begin
          // Relock at whatever alignment exists now
          if (ref_derived_pps && in_tol && ext_ref_enable) begin
            lock_q    <= REF_LOCK;
            lock_ph_q <= xdiv_q;
          end
        end
        REF_LOCK: begin
          if (ref_bad || !ext_ref_enable) begin
            lock_q <= REF_HUNT;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Counter source selection
  logic sec_tick;

  // Off oscillator with no reference leaves sec_tick low: counters hold
  assign sec_tick = osc_off_bit ? (ext_ref_enable && ref_derived_pps)
                                : xtal_derived_pps;

  // ==========================================================
  // APB decode
  logic        setup;
  logic        wr_en;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_time;
  logic        hit_date;
  logic        hit_alm1;
  logic        hit_alm2;
  logic        mapped;
  logic [4:0]  wr_hour;
  logic [4:0]  rd_hour;
  logic        rd_pm;
  logic [31:0] rdata_d;
  logic [5:0]  cs;
  logic [5:0]  cm;
  logic [4:0]  ch;
  logic [2:0]  cdw;
  logic [4:0]  cdt;
  logic [3:0]  cmo;
  logic [6:0]  cyr;

  assign setup    = psel && !penable;
  assign wr_en    = psel && penable && pready && pwrite;
  assign hit_ctrl = paddr == OFF_CTRL;
  assign hit_stat = paddr == OFF_STATUS;
  assign hit_time = paddr == OFF_TIME;
  assign hit_date = paddr == OFF_DATE;
  assign hit_alm1 = paddr == OFF_ALM1;
  assign hit_alm2 = paddr == OFF_ALM2;
  assign mapped   = hit_ctrl | hit_stat | hit_time | hit_date | hit_alm1 | hit_alm2;

  // Hours stored as 0..23; 12h form only at the register port
  assign wr_hour = !mode12 ? pwdata[T_HR +: 5] :
                   (pwdata[T_HR +: 5] == 5'd12) ? (pwdata[T_PM] ? 5'd12 : 5'd0) :
                   (pwdata[T_PM] ? pwdata[T_HR +: 5] + 5'd12 : pwdata[T_HR +: 5]);
  assign rd_pm   = ch >= 5'd12;
  assign rd_hour = !mode12 ? ch :
                   (ch == 5'd0) ? 5'd12 :
                   rd_pm && ch != 5'd12 ? ch - 5'd12 : ch;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata_d[7:0] = ctrl_q;
    end else if (hit_stat) begin
      rdata_d[4:0] = stat_q;
    end else if (hit_time) begin
      rdata_d[T_SEC +: 6] = cs;
      rdata_d[T_MIN +: 6] = cm;
      rdata_d[T_HR  +: 5] = rd_hour;
      rdata_d[T_PM]       = mode12 && rd_pm;
    end else if (hit_date) begin
      rdata_d[D_DOW +: 3] = cdw;
      rdata_d[D_DAT +: 5] = cdt;
      rdata_d[D_MON +: 4] = cmo;
      rdata_d[D_YR  +: 7] = cyr;
    end else if (hit_alm1) begin
      rdata_d[16:0] = alm1_q;
    end else if (hit_alm2) begin
      rdata_d[16:0] = alm2_q;
    end
  end

  // ==========================================================
  // Calendar
  rtctb_cal u_cal (
    .pclk      (pclk),
    .presetn   (presetn),
    .sec_tick  (sec_tick),
    .load_time (wr_en && hit_time),
    .load_date (wr_en && hit_date),
    .new_sec   (pwdata[T_SEC +: 6]),
    .new_min   (pwdata[T_MIN +: 6]),
    .new_hour  (wr_hour),
    .new_dow   (pwdata[D_DOW +: 3]),
    .new_date  (pwdata[D_DAT +: 5]),
    .new_month (pwdata[D_MON +: 4]),
    .new_year  (pwdata[D_YR +: 7]),
    .sec_q     (cs),
    .min_q     (cm),
    .hour_q    (ch),
    .dow_q     (cdw),
    .date_q    (cdt),
    .month_q   (cmo),
    .year_q    (cyr)
  );

  // ==========================================================
  // Alarms, oscillator halt and bus timeout
  logic [16:0] now_hms;
  logic        tick_q;
  logic        a1_hit;
  logic        a2_hit;
  logic [22:0] osf_cnt_q;
  logic        osf_set;
  logic [10:0] tmo_cnt_q;
  logic        tmo_q;
  logic        tmo_rise;
  logic [4:0]  set_vec;
  logic [4:0]  clr_vec;
  logic        sq_q;

  localparam logic [22:0] OSF_LIM  = 23'(OSF_LIMIT);
  localparam logic [10:0] TMO_LIM  = 11'(TMO_MIN_TICKS);

  // Alarm words hold {hour, minute, second} in 24h form
  assign now_hms = {ch, cm, cs};
  assign a1_hit  = tick_q && now_hms == alm1_q;
  assign a2_hit  = tick_q && now_hms == alm2_q;
  assign osf_set = osf_cnt_q >= OSF_LIM;
  // Firing at the minimum limit also meets the maximum limit
  assign tmo_rise = !tmo_q && !scl_s && xtal_edge &&
                    tmo_cnt_q == TMO_LIM - 11'h001;

  assign set_vec = {tmo_rise, osf_set, ref_bad, a2_hit, a1_hit};
  assign clr_vec = (wr_en && hit_stat) ? pwdata[4:0] : 5'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q    <= 1'b0;
      osf_cnt_q <= '0;
      tmo_cnt_q <= '0;
      tmo_q     <= 1'b0;
      sq_q      <= 1'b0;
    end else begin
      tick_q <= sec_tick;
      if (sec_tick) sq_q <= !sq_q;
      if (xtal_edge) begin
        osf_cnt_q <= '0;
      end else if (!osf_set) begin
        osf_cnt_q <= osf_cnt_q + 23'h000001;
      end
      if (scl_s) begin
        tmo_cnt_q <= '0;
        tmo_q     <= 1'b0;
      end else if (xtal_edge && !tmo_q) begin
        tmo_cnt_q <= tmo_cnt_q + 11'h001;
        if (tmo_rise) tmo_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Register writes, status flags and APB answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= CTRL_RST;
      stat_q  <= {1'b0, STAT_RST};
      alm1_q  <= '0;
      alm2_q  <= '0;
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      if (wr_en && hit_ctrl) ctrl_q <= pwdata[7:0];
      if (wr_en && hit_alm1) alm1_q <= pwdata[16:0];
      if (wr_en && hit_alm2) alm2_q <= pwdata[16:0];
      // A new event in the clearing cycle survives the clear
      stat_q  <= (stat_q & ~clr_vec) | set_vec;
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup) prdata <= rdata_d;
    end
  end

  // ==========================================================
  // Pin drivers
  logic irq_a_n;
  logic irq_b_n;

  assign irq_a_n = !(ctrl_q[C_A1IE] && stat_q[S_A1F]);
  assign irq_b_n = !(ctrl_q[C_A2IE] && stat_q[S_A2F]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refin_or_irq_a_pin_o  <= 1'b0;
      refin_or_irq_a_pin_oe <= 1'b0;
      wave_or_irq_b_pin     <= 1'b1;
      sda_o                 <= 1'b0;
      sda_oe                <= 1'b0;
      bus_reset             <= 1'b0;
      byte_discard          <= 1'b0;
    end else begin
      refin_or_irq_a_pin_o  <= 1'b0;
      // Open drain: only pulls low, never while used as reference input
      refin_or_irq_a_pin_oe <= !ext_ref_enable && !irq_a_n;
      wave_or_irq_b_pin     <= ctrl_q[C_INTCN] ? irq_b_n : sq_q;
      sda_o                 <= 1'b0;
      sda_oe                <= sda_drive_req && !tmo_q && !tmo_rise;
      bus_reset             <= tmo_q || tmo_rise;
      byte_discard          <= tmo_rise && wr_byte_pending;
    end
  end
endmodule : rtctb_top

/* File: tb/rtctb_i2c_ctl.sv */
`timescale 1ns/1ps
// Bus controller: idle high, clocks only in frames, or stalls SCL low
module rtctb_i2c_ctl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hold_low,
  input wire logic run,
  output logic     scl
);
  logic [7:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      scl   <= 1'b1;
    end else if (hold_low) begin
      scl <= 1'b0;
    end else if (run) begin
      cnt_q <= (cnt_q == 8'hF9) ? 8'h00 : cnt_q + 8'h01;
      if (cnt_q == 8'hF9) scl <= ~scl;
    end else begin
      scl <= 1'b1;
    end
  end
endmodule : rtctb_i2c_ctl

/* File: tb/rtctb_monitor.sv */
`timescale 1ns/1ps
module rtctb_monitor
  import rtctb_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       refin_or_irq_a_pin_o,
  input wire logic       scl_i,
  input wire logic       sda_drive_req,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       bus_reset,
  input wire logic       byte_discard
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Register bus
  chk_ready_pulse:
    assert property (psel && !penable |=> pready ##1 !pready) else $error("pready not one cycle");
  chk_unmapped_err:
    assert property (psel && !penable && paddr > 8'h14 |=> pslverr && pready)
    else $error("unmapped access not refused");
  chk_err_with_ready:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  // ==========================================
  // Pins and bus timeout
  chk_pin_a_drain:
    assert property (refin_or_irq_a_pin_o == 1'b0) else $error("pin A driven high");
  chk_sda_drain:
    assert property (sda_o == 1'b0) else $error("sda driven high");
  chk_sda_released:
    assert property (bus_reset |-> !sda_oe) else $error("sda held during timeout");
  chk_sda_follows:
    assert property (!bus_reset && !$past(bus_reset) |-> sda_oe == $past(sda_drive_req))
    else $error("sda enable does not follow request");
  chk_discard_start:
    assert property (byte_discard |-> $rose(bus_reset) ##1 !byte_discard)
    else $error("discard pulse misplaced");
  chk_timeout_clear:
    assert property ((bus_reset && scl_i) [*6] |=> !bus_reset) else $error("timeout stuck");
  chk_low_before:
    assert property ($rose(bus_reset) |-> !$past(scl_i, 5)) else $error("timeout with scl high");
endmodule : rtctb_monitor

bind rtctb_top rtctb_monitor u_rtctb_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .refin_or_irq_a_pin_o(refin_or_irq_a_pin_o),
  .scl_i(scl_i), .sda_drive_req(sda_drive_req), .sda_o(sda_o), .sda_oe(sda_oe),
  .bus_reset(bus_reset), .byte_discard(byte_discard));

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench
  import rtctb_pkg::*;
;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic er;} rtctb_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, refin_or_irq_a_pin_o, refin_or_irq_a_pin_oe, wave_or_irq_b_pin;
  logic scl_i, sda_o, sda_oe, bus_reset, byte_discard, err;
  logic sda_drive_req = 1'b0, wr_byte_pending = 1'b0, xtal_clk = 1'b0, ref_src = 1'b0;
  logic hold = 1'b0, run = 1'b0, disc_seen = 1'b0;
  int   fail_count = 0, samples_checked = 0, n, xcnt = 0;
  // Open-drain pin A: pulled low by the design, else the reference source
  wire  refin_or_irq_a_pin_i = refin_or_irq_a_pin_oe ? refin_or_irq_a_pin_o : ref_src;
  rtctb_row_t rows[10] = '{
    '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h8, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h0C, 32'h0, 32'h00010101, 1'b0},
    '{1'b1, 8'h10, 32'h00010203, 32'h0, 1'b0}, '{1'b0, 8'h10, 32'h0, 32'h00010203, 1'b0},
    '{1'b1, 8'h14, 32'hFFFE0041, 32'h0, 1'b0}, '{1'b0, 8'h14, 32'h0, 32'h00000041, 1'b0},
    '{1'b1, 8'h18, 32'h1, 32'h0, 1'b1}, '{1'b0, 8'h1C, 32'h0, 32'h0, 1'b1}};

  always #2.5 pclk = ~pclk;
  initial #3 forever #40 xtal_clk = ~xtal_clk;
  always @(posedge xtal_clk) xcnt++;
  always @(posedge pclk) if (byte_discard === 1'b1) disc_seen <= 1'b1;

  rtctb_top #(.OSF_LIMIT(200)) u_rtctb_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xtal_clk(xtal_clk), .refin_or_irq_a_pin_i(refin_or_irq_a_pin_i),
    .refin_or_irq_a_pin_o(refin_or_irq_a_pin_o), .refin_or_irq_a_pin_oe(refin_or_irq_a_pin_oe),
    .wave_or_irq_b_pin(wave_or_irq_b_pin), .scl_i(scl_i), .sda_drive_req(sda_drive_req),
    .wr_byte_pending(wr_byte_pending), .sda_o(sda_o), .sda_oe(sda_oe), .bus_reset(bus_reset),
    .byte_discard(byte_discard));
  rtctb_i2c_ctl u_rtctb_i2c_ctl (.pclk(pclk), .presetn(presetn), .hold_low(hold), .run(run),
                                 .scl(scl_i));
  // ==========================================
  // Helpers
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a stalled access
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    chk("pready", {31'h0, pready}, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task ref_pulses();
    repeat (3) begin
      ref_src <= 1'b1;
      repeat (40) @(posedge pclk);
      ref_src <= 1'b0;
      repeat (40) @(posedge pclk);
    end
  endtask : ref_pulses

  task wrap_up();
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  // ==========================================
  // Sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk("read data", rd, rows[i].x);
      chk("slave error", {31'h0, err}, {31'h0, rows[i].er});
    end
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", rd, 32'h10);
    apb(1'b1, 8'h00, 32'h0);
    // Short SCL frames must keep clearing the idle count
    run             <= 1'b1;
    sda_drive_req   <= 1'b1;
    wr_byte_pending <= 1'b1;
    repeat (3000) @(posedge pclk);
    chk("no timeout", {31'h0, bus_reset}, 32'h0);
    chk("sda enable", {31'h0, sda_oe}, 32'h1);
    run  <= 1'b0;
    hold <= 1'b1;
    @(posedge pclk);
    xcnt = 0;
    n = 0;
    while (bus_reset !== 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    chk("timeout early", 32'(xcnt >= TMO_MIN_TICKS), 32'h1);
    chk("timeout late", 32'(xcnt <= TMO_MIN_TICKS + 2), 32'h1);
    @(posedge pclk);
    chk("sda released", {31'h0, sda_oe}, 32'h0);
    chk("discard", {31'h0, disc_seen}, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk("timeout flag", {31'h0, rd[4]}, 32'h1);
    hold            <= 1'b0;
    sda_drive_req   <= 1'b0;
    wr_byte_pending <= 1'b0;
    repeat (10) @(posedge pclk);
    chk("timeout end", {31'h0, bus_reset}, 32'h0);
    apb(1'b1, 8'h04, 32'h1F);
    apb(1'b0, 8'h04, 32'h0);
    chk("halt clear", {31'h0, rd[3]}, 32'h0);
    // Oscillator off: no timeout however long SCL stays low
    apb(1'b1, 8'h00, 32'h1);
    hold <= 1'b1;
    repeat (15000) @(posedge pclk);
    chk("no timeout osc off", {31'h0, bus_reset}, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk("halt and timeout", {30'h0, rd[4:3]}, 32'h1);
    hold <= 1'b0;
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h00, 32'h3);
    ref_pulses();
    apb(1'b0, 8'h08, 32'h0);
    chk("ref seconds", rd, 32'h3);
    chk("square wave", {31'h0, wave_or_irq_b_pin}, 32'h1);
    repeat (2000) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h1);
    ref_pulses();
    apb(1'b0, 8'h08, 32'h0);
    chk("held seconds", rd, 32'h3);
    // Two alarms one second apart, then 12h readout and alarm pins
    apb(1'b1, 8'h08, 32'h0010_0802);
    apb(1'b1, 8'h14, 32'h0001_0204);
    apb(1'b1, 8'h00, 32'h0000_00E3);
    ref_pulses();
    apb(1'b1, 8'h00, 32'h0000_00F1);
    apb(1'b0, 8'h08, 32'h0);
    chk("12h time", rd, 32'h0024_0805);
    chk("pin A alarm", {31'h0, refin_or_irq_a_pin_oe}, 32'h1);
    chk("pin B alarm", {31'h0, wave_or_irq_b_pin}, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk("alarm flags", {29'h0, rd[2:0]}, 32'h3);
    // Reference pulses far too fast for the crystal count
    apb(1'b1, 8'h00, 32'h2);
    ref_pulses();
    apb(1'b0, 8'h04, 32'h0);
    chk("lost flag", {31'h0, rd[2]}, 32'h1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    chk("status after reset", rd, 32'h8);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl after reset", rd, 32'h0);
    chk("wave after reset", {31'h0, wave_or_irq_b_pin}, 32'h0);
    wrap_up();
  end

  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end
endmodule : testbench
